// file: tb/nbs_properties.sv
// Checker of the splitter link: groups, lanes, pending status.
// Assumes the interface signals wired in plainly by tb_top.
`timescale 1ns/1ps
`default_nettype none
module nbs_properties (
	input wire logic        clock,
	input wire logic        rst_n,
	input wire logic        bus_wide16,
	input wire logic        addr_strobe,
	input wire logic [31:0] bus_addr,
	input wire logic        burst_flag,
	input wire logic        data_valid,
	input wire logic        burst_last,
	input wire logic [1:0]  low_addr_pair,
	input wire logic        lane0_enable_n,
	input wire logic        lane1_enable_n,
	input wire logic        lane2_enable_n,
	input wire logic        lane3_enable_n,
	input wire logic        data_ready,
	input wire logic        pending_bus_access_out
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	logic [3:0] lanes;
	logic [2:0] cnt_q;
	logic       done;
	// Lane vector and transfer end
	assign lanes = {lane3_enable_n, lane2_enable_n, lane1_enable_n, lane0_enable_n};
	assign done  = data_valid && data_ready;
	// Data cycles finished in the current group
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			cnt_q <= 3'h0;
		else if (addr_strobe)
			cnt_q <= 3'h0;
		else if (done)
			cnt_q <= cnt_q + 3'h1;
	end
	strobe_pulse_a: assert property (addr_strobe |=> !addr_strobe && data_valid)
		else $error("address cycle not followed by a data cycle");
	burst_open_a: assert property (addr_strobe && burst_flag |=> !burst_last)
		else $error("burst with a single data cycle");
	single_cycle_a: assert property (addr_strobe && !burst_flag |=> burst_last)
		else $error("single access with more data cycles");
	burst_len_a: assert property (done && burst_last && burst_flag |-> cnt_q >= 3'h1 && cnt_q <= 3'h3)
		else $error("burst length outside two to four");
	gap_free_a: assert property (done && !burst_last |=> data_valid)
		else $error("gap inside a burst");
	odd_start_a: assert property (addr_strobe && !bus_wide16 && bus_addr[1:0] == 2'h3 |-> !burst_flag)
		else $error("byte bus burst from offset three");
	short_two_a: assert property (addr_strobe && bus_wide16 && bus_addr[1:0] == 2'h2 |-> !burst_flag)
		else $error("short bus burst from offset two");
	byte_lane_a: assert property (data_valid && (!bus_wide16 || low_addr_pair[0])
		|-> lanes == ~(4'h1 << low_addr_pair))
		else $error("byte lanes do not match address pair");
	short_lane_a: assert property (data_valid && bus_wide16 && !low_addr_pair[0]
		|-> lanes == ~(4'h1 << low_addr_pair) || lanes == ~(4'h3 << low_addr_pair))
		else $error("short lanes do not match address pair");
	pair_hold_a: assert property (data_valid && !data_ready |=> $stable(low_addr_pair) && $stable(lanes))
		else $error("transfer fields moved before ready");
	pending_up_a: assert property (addr_strobe |-> pending_bus_access_out)
		else $error("address cycle without pending status");
endmodule
`default_nettype wire

// file: tb/tb_top.sv
// Bench: every size and offset on both widths, written then read back.
// Assumes the design files under verilog compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import nbs_pkg::*;
;
	logic        clock, rst_n, wide16, req_valid, req_write, core_stalled, other_req;
	logic        req_ready, rsp_done, other_grant;
	nbs_size_t   req_size;
	logic [31:0] req_addr, req_wdata, rsp_rdata, lfsr_q, a, d, m;
	logic [15:0] sig;
	logic [3:0]  mon_cnt;
	int          mismatches, cmp_count, n;
	nbs_if nbs_if_i ();
	nbs_dev nbs_dev_i (.clock(clock), .rst_n(rst_n), .lnk(nbs_if_i), .wide16(wide16),
		.req_valid(req_valid), .req_write(req_write), .req_size(req_size), .req_addr(req_addr),
		.req_wdata(req_wdata), .core_stalled(core_stalled), .req_ready(req_ready),
		.rsp_done(rsp_done), .rsp_rdata(rsp_rdata));
	nbs_host nbs_host_i (.clock(clock), .rst_n(rst_n), .lnk(nbs_if_i), .other_req(other_req),
		.other_grant(other_grant));
	nbs_properties nbs_properties_i (.clock(clock), .rst_n(rst_n), .bus_wide16(nbs_if_i.bus_wide16),
		.addr_strobe(nbs_if_i.addr_strobe), .bus_addr(nbs_if_i.bus_addr),
		.burst_flag(nbs_if_i.burst_flag), .data_valid(nbs_if_i.data_valid),
		.burst_last(nbs_if_i.burst_last), .low_addr_pair(nbs_if_i.low_addr_pair),
		.lane0_enable_n(nbs_if_i.lane0_enable_n), .lane1_enable_n(nbs_if_i.lane1_enable_n),
		.lane2_enable_n(nbs_if_i.lane2_enable_n), .lane3_enable_n(nbs_if_i.lane3_enable_n),
		.data_ready(nbs_if_i.data_ready), .pending_bus_access_out(nbs_if_i.pending_bus_access_out));
	function automatic logic [31:0] lfsr_next(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	// Data cycles per group, oldest group in the upper digits
	function automatic logic [15:0] exp_seq(input logic w, input logic [1:0] o, input int cnt);
		logic [15:0] s;
		logic [1:0]  p;
		logic [3:0]  c;
		s = 16'h0;
		p = o;
		while (cnt > 0) begin
			c = 4'h0;
			do begin
				if (w && !p[0] && cnt >= 2) begin
					p += 2'h2;
					cnt -= 2;
				end else begin
					p += 2'h1;
					cnt -= 1;
				end
				c += 4'h1;
			end while (cnt > 0 && p != 2'h0);
			s = {s[11:0], c};
		end
		return s;
	endfunction
	task automatic end_of_test();
		$display("Counts: %0d compares, %0d mismatches", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk_word(input string what, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic chk_seq(input string what, input logic [15:0] e, input logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic chk_bit(input string what, input logic e, input logic g);
		cmp_count++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %s expected %b seen %b", what, e, g);
		end
	endtask
	// One access: wait idle, offer for one edge, wait for completion
	task automatic access(input logic w, input logic wr, input nbs_size_t sz);
		int k;
		k = 0;
		while (req_ready !== 1'b1 && k < 2000) begin
			@(negedge clock);
			k++;
		end
		if (k >= 2000) begin
			mismatches++;
			$display("[ERR] request ready expected 1 seen 0");
			end_of_test();
		end
		{wide16, req_write, req_addr, req_wdata} = {w, wr, a, d};
		req_size = sz;
		sig = 16'h0;
		req_valid = 1'b1;
		@(negedge clock);
		req_valid = 1'b0;
		while (rsp_done !== 1'b1 && k < 4000) begin
			@(negedge clock);
			k++;
		end
		if (k >= 4000) begin
			mismatches++;
			$display("[ERR] access completion expected 1 seen 0");
			end_of_test();
		end
	endtask
	// Clock
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	// Group signature from the link
	always @(posedge clock) begin
		if (nbs_if_i.data_valid === 1'b1 && nbs_if_i.data_ready === 1'b1) begin
			mon_cnt = mon_cnt + 4'h1;
			if (nbs_if_i.burst_last === 1'b1) begin
				sig = {sig[11:0], mon_cnt};
				mon_cnt = 4'h0;
			end
		end
	end
	// Random stall and rival master, stall output checked one cycle late
	always @(negedge clock) begin
		if (rst_n) begin
			chk_bit("stall out", core_stalled, nbs_if_i.processor_stall_out);
			chk_bit("other grant clear", 1'b0, other_grant & (nbs_if_i.bus_grant |
				nbs_if_i.addr_strobe | nbs_if_i.data_valid));
			lfsr_q <= lfsr_next(lfsr_q);
			other_req <= lfsr_q[4] & lfsr_q[9];
			core_stalled <= lfsr_q[7] & lfsr_q[11] & lfsr_q[2];
		end
	end
	// Main sequence
	initial begin
		{rst_n, wide16, req_valid, req_write, core_stalled, other_req} = 6'h0;
		{req_addr, req_wdata, sig, mon_cnt, mismatches, cmp_count} = '0;
		req_size = NBS_SZ_BYTE;
		lfsr_q = 32'h91FC916D;
		repeat (4) @(negedge clock);
		rst_n = 1'b1;
		@(negedge clock);
		for (int w = 0; w < 2; w++) begin
			for (int s = 0; s < 3; s++) begin
				for (int o = 0; o < 4; o++) begin
					n = (s == 0) ? 1 : (s == 1) ? 2 : 4;
					m = (n == 4) ? 32'hFFFFFFFF : (32'h1 << (8 * n)) - 32'h1;
					a = {26'h0, lfsr_q[5:2], o[1:0]};
					d = {lfsr_q[15:0], lfsr_q[31:16]};
					access(w[0], 1'b1, nbs_size_t'(s));
					chk_seq("write groups", exp_seq(w[0], o[1:0], n), sig);
					access(w[0], 1'b0, nbs_size_t'(s));
					chk_seq("read groups", exp_seq(w[0], o[1:0], n), sig);
					chk_word("read data", d & m, rsp_rdata & m);
					$display("test done: wide %0d size %0d offset %0d", w, s, o);
				end
			end
		end
		repeat (3) @(negedge clock);
		chk_bit("pending idle", 1'b0, nbs_if_i.pending_bus_access_out);
		end_of_test();
	end
endmodule
`default_nettype wire

// file: verilog/nbs_dev.sv
// Device end: splits a processor access into bursts and single cycles
// on an 8-bit or 16-bit bus, and drives pending and stall status.
// Assumes the far end grants the bus and ends each data cycle with ready.
`timescale 1ns/1ps
`default_nettype none
`include "nbs_regs.svh"
module nbs_dev
	import nbs_pkg::*;
(
	input  wire logic      clock,
	input  wire logic      rst_n,
	nbs_if.dev             lnk,
	input  wire logic      wide16,
	input  wire logic      req_valid,
	input  wire logic      req_write,
	input  wire nbs_size_t req_size,
	input  wire logic [31:0] req_addr,
	input  wire logic [31:0] req_wdata,
	input  wire logic      core_stalled,
	output var  logic      req_ready,
	output var  logic      rsp_done,
	output var  logic [31:0] rsp_rdata
);
	nbs_state_t  st_q;
	logic [31:0] addr_q;
	logic [2:0]  rem_q;
	logic [1:0]  idx_q;
	logic [31:0] wdat_q;
	logic [31:0] acc_q;
	logic        wr_q;
	logic        wide_q;
	logic        ads_q, burst_q, dv_q, last_q, done_q, rdy_q;
	logic        pend_q, stall_q;
	logic [31:0] baddr_q;
	logic [1:0]  pair_q;
	logic [3:0]  lanes_q;
	logic [15:0] wd_q;
	logic [1:0]  cur_sz, drv_sz;
	logic        cur_last, drv_last;
	logic [1:0]  nxt_a, src_a, nxt_idx, src_idx;
	logic [2:0]  nxt_rem, src_rem;
	logic [15:0] drv_wd;
	logic [7:0]  b0, b1;

	// Size of one transfer: bytes only on the narrow bus
	function automatic logic [1:0] xfer_sz(input logic w, input logic [1:0] a,
		input logic [2:0] rem);
		if (w && !a[0] && rem != `NBS_ONE_REM)
			return `NBS_SHORT_SZ;
		return `NBS_BYTE_SZ;
	endfunction

	// Group of transfers stops at the word boundary
	function automatic logic grp_last(input logic [1:0] a, input logic [1:0] sz,
		input logic [2:0] rem);
		logic [2:0] sum;
		sum = {1'b0, a} + {1'b0, sz};
		return sum == `NBS_WORD_BYTES || rem == {1'b0, sz};
	endfunction

	// Group is a burst only with two or more transfers
	function automatic logic is_burst(input logic w, input logic [1:0] a,
		input logic [2:0] rem);
		logic [2:0] grp;
		grp = `NBS_WORD_BYTES - {1'b0, a};
		if (rem < grp)
			grp = rem;
		if (w)
			return grp > `NBS_TWO_REM || (grp == `NBS_TWO_REM && a[0]);
		return grp > `NBS_ONE_REM;
	endfunction

	// Bytes in a request
	function automatic logic [2:0] size_bytes(input nbs_size_t s);
		unique case (s)
			NBS_SZ_BYTE:  return `NBS_ONE_REM;
			NBS_SZ_SHORT: return `NBS_TWO_REM;
			default:      return `NBS_WORD_BYTES;
		endcase
	endfunction

	// Current transfer and the one after it
	always_comb begin
		cur_sz   = xfer_sz(wide_q, addr_q[1:0], rem_q);
		cur_last = grp_last(addr_q[1:0], cur_sz, rem_q);
		nxt_a    = addr_q[1:0] + cur_sz;
		nxt_rem  = rem_q - {1'b0, cur_sz};
		nxt_idx  = idx_q + cur_sz;
		src_a    = (st_q == NBS_DATA) ? nxt_a : addr_q[1:0];
		src_rem  = (st_q == NBS_DATA) ? nxt_rem : rem_q;
		src_idx  = (st_q == NBS_DATA) ? nxt_idx : idx_q;
		drv_sz   = xfer_sz(wide_q, src_a, src_rem);
		drv_last = grp_last(src_a, drv_sz, src_rem);
		b0       = wdat_q[src_idx*8 +: 8];
		b1       = wdat_q[(src_idx + 2'h1)*8 +: 8];
		if (!wide_q)
			drv_wd = {8'h00, b0};
		else if (drv_sz == `NBS_SHORT_SZ)
			drv_wd = {b1, b0};
		else if (src_a[0])
			drv_wd = {b0, 8'h00};
		else
			drv_wd = {8'h00, b0};
	end

	// Sequencer over address and data cycles
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= NBS_IDLE;
		end else begin
			unique case (st_q)
				NBS_IDLE: if (req_valid) st_q <= NBS_WAIT;
				NBS_WAIT: if (lnk.bus_grant) st_q <= NBS_ADDR;
				NBS_ADDR: st_q <= NBS_DATA;
				NBS_DATA: if (lnk.data_ready && cur_last)
					st_q <= (rem_q == {1'b0, cur_sz}) ? NBS_IDLE : NBS_WAIT;
			endcase
		end
	end

	// Request capture and progress through the bytes
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			addr_q <= '0;
			rem_q  <= '0;
			idx_q  <= '0;
			wdat_q <= '0;
			wr_q   <= 1'b0;
			wide_q <= 1'b0;
		end else if (st_q == NBS_IDLE && req_valid) begin
			addr_q <= req_addr;
			rem_q  <= size_bytes(req_size);
			idx_q  <= '0;
			wdat_q <= req_wdata;
			wr_q   <= req_write;
			wide_q <= wide16;
		end else if (st_q == NBS_DATA && lnk.data_ready) begin
			addr_q <= addr_q + {30'h0, cur_sz};
			rem_q  <= nxt_rem;
			idx_q  <= nxt_idx;
		end
	end

	// Read bytes gathered into the response word
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			acc_q <= '0;
		end else if (st_q == NBS_DATA && lnk.data_ready) begin
			if (!wide_q)
				acc_q[idx_q*8 +: 8] <= lnk.rd_data[7:0];
			else if (cur_sz == `NBS_SHORT_SZ)
				acc_q[idx_q*8 +: 16] <= lnk.rd_data;
			else if (addr_q[0])
				acc_q[idx_q*8 +: 8] <= lnk.rd_data[15:8];
			else
				acc_q[idx_q*8 +: 8] <= lnk.rd_data[7:0];
		end
	end

	// Address cycle outputs
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ads_q   <= 1'b0;
			burst_q <= 1'b0;
			baddr_q <= '0;
		end else begin
			ads_q <= st_q == NBS_WAIT && lnk.bus_grant;
			if (st_q == NBS_WAIT && lnk.bus_grant) begin
				baddr_q <= addr_q;
				burst_q <= is_burst(wide_q, addr_q[1:0], rem_q);
			end
		end
	end

	// Data cycle outputs, refreshed for each transfer of a burst
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			dv_q    <= 1'b0;
			last_q  <= 1'b0;
			pair_q  <= `NBS_ZERO_PAIR;
			lanes_q <= `NBS_LANES_OFF;
			wd_q    <= '0;
		end else if (st_q == NBS_ADDR ||
			(st_q == NBS_DATA && lnk.data_ready && !cur_last)) begin
			dv_q    <= 1'b1;
			last_q  <= drv_last;
			pair_q  <= src_a;
			lanes_q <= ~(((drv_sz == `NBS_SHORT_SZ) ? `NBS_LANE_SHORT :
				`NBS_LANE_BYTE) << src_a);
			wd_q    <= drv_wd;
		end else if (st_q == NBS_DATA && lnk.data_ready) begin
			dv_q    <= 1'b0;
			last_q  <= 1'b0;
			lanes_q <= `NBS_LANES_OFF;
		end
	end

	// User answer, pending and stall status
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			done_q  <= 1'b0;
			rdy_q   <= 1'b0;
			pend_q  <= 1'b0;
			stall_q <= 1'b0;
		end else begin
			done_q  <= st_q == NBS_DATA && lnk.data_ready && cur_last &&
				rem_q == {1'b0, cur_sz};
			rdy_q   <= st_q == NBS_IDLE && !req_valid;
			pend_q  <= (st_q == NBS_IDLE && req_valid) || st_q == NBS_WAIT ||
				(st_q == NBS_DATA && !(lnk.data_ready && cur_last &&
				rem_q == {1'b0, cur_sz})) || st_q == NBS_ADDR;
			stall_q <= core_stalled;
		end
	end

	assign lnk.bus_wide16             = wide_q;
	assign lnk.addr_strobe            = ads_q;
	assign lnk.bus_addr               = baddr_q;
	assign lnk.burst_flag             = burst_q;
	assign lnk.bus_write              = wr_q;
	assign lnk.data_valid             = dv_q;
	assign lnk.burst_last             = last_q;
	assign lnk.low_addr_pair          = pair_q;
	assign lnk.lane0_enable_n         = lanes_q[0];
	assign lnk.lane1_enable_n         = lanes_q[1];
	assign lnk.lane2_enable_n         = lanes_q[2];
	assign lnk.lane3_enable_n         = lanes_q[3];
	assign lnk.wr_data                = wd_q;
	assign lnk.processor_stall_out    = stall_q;
	assign lnk.pending_bus_access_out = pend_q;
	assign req_ready                  = rdy_q;
	assign rsp_done                   = done_q;
	assign rsp_rdata                  = acc_q;
endmodule
`default_nettype wire

// file: verilog/nbs_host.sv
// Far end: arbiter plus narrow memory controller with its own memory.
// Assumes the splitter drives the link from registers on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "nbs_regs.svh"
module nbs_host
	import nbs_pkg::*;
(
	input  wire logic clock,
	input  wire logic rst_n,
	nbs_if.host       lnk,
	input  wire logic other_req,
	output var  logic other_grant
);
	logic [31:0]          mem [`NBS_MEM_WORDS];
	logic [`NBS_MEM_AW-1:0] word_q;
	logic [1:0]           wait_q;
	logic                 rdy_q;
	logic                 grant_q;
	logic                 ogrant_q;
	logic [15:0]          rd_q;
	logic [3:0]           lanes;
	logic                 need;

	// Bus need of the processor, lanes taken live
	always_comb begin
		need  = lnk.processor_stall_out | lnk.pending_bus_access_out;
		lanes = ~{lnk.lane3_enable_n, lnk.lane2_enable_n,
			lnk.lane1_enable_n, lnk.lane0_enable_n};
	end

	// Stall first, then other master, then pending
	// Grant kept while the splitter may start an address cycle on it
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			grant_q  <= 1'b0;
			ogrant_q <= 1'b0;
		end else if (lnk.data_valid || lnk.addr_strobe ||
			(grant_q && lnk.pending_bus_access_out)) begin
			grant_q  <= grant_q;
			ogrant_q <= 1'b0;
		end else if (lnk.processor_stall_out) begin
			grant_q  <= 1'b1;
			ogrant_q <= 1'b0;
		end else begin
			grant_q  <= need & ~other_req;
			ogrant_q <= other_req;
		end
	end

	// Word address caught on each address cycle
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			word_q <= '0;
		end else if (lnk.addr_strobe) begin
			word_q <= lnk.bus_addr[`NBS_MEM_AW+1:2];
		end
	end

	// Wait states then one ready per data cycle
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wait_q <= '0;
			rdy_q  <= 1'b0;
		end else if (!lnk.data_valid || rdy_q) begin
			wait_q <= '0;
			rdy_q  <= 1'b0;
		end else if (wait_q == `NBS_WAIT_STATES) begin
			rdy_q  <= 1'b1;
		end else begin
			wait_q <= wait_q + 2'h1;
		end
	end

	// Memory write through the enabled byte lanes
	always_ff @(posedge clock) begin
		if (lnk.data_valid && rdy_q && lnk.bus_write) begin
			for (int i = 0; i < 4; i++) begin
				if (lanes[i]) begin
					mem[word_q][i*8 +: 8] <= (lnk.bus_wide16 && i[0]) ?
						lnk.wr_data[15:8] : lnk.wr_data[7:0];
				end
			end
		end
	end

	// Read data steered to the bus lanes
	always_comb begin
		if (lnk.bus_wide16) begin
			rd_q = lnk.low_addr_pair[1] ? mem[word_q][31:16] : mem[word_q][15:0];
		end else begin
			rd_q = {8'h00, mem[word_q][lnk.low_addr_pair*8 +: 8]};
		end
	end

	assign lnk.rd_data    = rd_q;
	assign lnk.data_ready = rdy_q;
	assign lnk.bus_grant  = grant_q;
	assign other_grant    = ogrant_q;
endmodule
`default_nettype wire

// file: verilog/nbs_if.sv
// Link between the splitter and the narrow memory controller with arbiter.
// Assumes one clock shared by both ends.
`timescale 1ns/1ps
`default_nettype none
interface nbs_if;
	logic        bus_wide16;             // Bus is 16 bits wide
	logic        addr_strobe;            // Address cycle
	logic [31:0] bus_addr;               // Address on address cycle
	logic        burst_flag;             // Address cycle opens a burst
	logic        bus_write;              // Direction, 1 write
	logic        data_valid;             // Data cycle in progress
	logic        burst_last;             // Last data cycle of group
	logic [1:0]  low_addr_pair;          // Low address bits each cycle
	logic        lane0_enable_n;
	logic        lane1_enable_n;
	logic        lane2_enable_n;
	logic        lane3_enable_n;
	logic [15:0] wr_data;
	logic [15:0] rd_data;
	logic        data_ready;             // Controller ends a data cycle
	logic        bus_grant;              // Arbiter grants the bus
	logic        processor_stall_out;
	logic        pending_bus_access_out;
	modport dev (
		output bus_wide16, addr_strobe, bus_addr, burst_flag, bus_write, data_valid,
		output burst_last, low_addr_pair, lane0_enable_n, lane1_enable_n,
		output lane2_enable_n, lane3_enable_n, wr_data,
		output processor_stall_out, pending_bus_access_out,
		input  rd_data, data_ready, bus_grant
	);
	modport host (
		input  bus_wide16, addr_strobe, bus_addr, burst_flag, bus_write, data_valid,
		input  burst_last, low_addr_pair, lane0_enable_n, lane1_enable_n,
		input  lane2_enable_n, lane3_enable_n, wr_data,
		input  processor_stall_out, pending_bus_access_out,
		output rd_data, data_ready, bus_grant
	);
endinterface
`default_nettype wire

// file: verilog/nbs_pkg.sv
// Types shared by both ends of the narrow bus splitter.
// Assumes nothing beyond the constants header.
`default_nettype none
package nbs_pkg;
	// Size of a processor access
	typedef enum logic [1:0] {
		NBS_SZ_BYTE,
		NBS_SZ_SHORT,
		NBS_SZ_WORD
	} nbs_size_t;
	// Device sequencer states
	typedef enum logic [1:0] {
		NBS_IDLE,
		NBS_WAIT,
		NBS_ADDR,
		NBS_DATA
	} nbs_state_t;
endpackage
`default_nettype wire

// file: verilog/nbs_regs.svh
// Constants of the narrow bus burst splitter: sizes, offsets, timing.
// Assumes inclusion by both link ends, nbs_dev and nbs_host.
`ifndef NBS_REGS_SVH
`define NBS_REGS_SVH
`define NBS_WORD_BYTES   3'h4
`define NBS_BYTE_SZ      2'h1
`define NBS_SHORT_SZ     2'h2
`define NBS_ONE_REM      3'h1
`define NBS_TWO_REM      3'h2
`define NBS_THREE_REM    3'h3
`define NBS_LANE_BYTE    4'h1
`define NBS_LANE_SHORT   4'h3
`define NBS_LANES_OFF    4'hF
`define NBS_ZERO_PAIR    2'h0
`define NBS_WAIT_STATES  2'h1
`define NBS_MEM_AW       4
`define NBS_MEM_WORDS    16
`endif
